// ### rtl/cdd_top.v
// Instruction decoder and address pointer of a character display controller.
`timescale 1ns/1ps
`include "cdd_defs.vh"
module cdd_top #(
	parameter BUSY_CYC = (`CDD_BUSY_NS * `CDD_CLK_MHZ + 999) / 1000,
	parameter CLEAR_CYC = (`CDD_CLEAR_NS * `CDD_CLK_MHZ + 999) / 1000,
	parameter DATA_CYC = (`CDD_DATA_NS * `CDD_CLK_MHZ + 999) / 1000,
	parameter BLINK_CYC = (`CDD_BLINK_NS / 1000) * `CDD_CLK_MHZ
) (
	sys_clk, // System clock, 125 MHz.
	nrst, // Asynchronous active-low reset.
	bus_addr, // Bit 0 is the register select line.
	bus_wdata, // Host write data.
	bus_wr, // Write strobe.
	bus_rd, // Read strobe.
	bus_rdata, // Read data, valid the cycle after the read strobe.
	internal_op_pending, // High while an operation executes.
	cursor_on, // Cursor visible.
	blink_on, // Cursor blink enabled.
	blink_phase, // High while the cursor cell shows all dots.
	panel_on, // Display visible.
	entry_inc, // Entry direction increments.
	scroll_on_write, // Whole screen scroll on display writes.
	wide_bus_select, // 8-bit host bus.
	two_rows, // Two-row mode.
	tall_glyph, // 5x11 dot glyphs.
	screen_offset, // Whole display shift position.
	address_pointer, // Current pointer.
	glyph_sel // Data accesses go to glyph RAM.
);
	input wire sys_clk;
	input wire nrst;
	input wire [0:0] bus_addr;
	input wire [7:0] bus_wdata;
	input wire bus_wr;
	input wire bus_rd;
	output reg [7:0] bus_rdata;
	output wire internal_op_pending;
	output wire cursor_on;
	output wire blink_on;
	output wire blink_phase;
	output wire panel_on;
	output wire entry_inc;
	output wire scroll_on_write;
	output wire wide_bus_select;
	output wire two_rows;
	output wire tall_glyph;
	output wire [6:0] screen_offset;
	output wire [6:0] address_pointer;
	output wire glyph_sel;

	localparam ST_IDLE = 2'h0;
	localparam ST_BUSY = 2'h1;
	localparam ST_CLEAR = 2'h2;

	reg rst_s1_r, rst_s2_r;
	wire rst_n = rst_s2_r;
	reg [1:0] state_r;
	reg [20:0] busy_cnt_r;
	reg [6:0] ptr_r;
	reg [6:0] ofs_r;
	reg glyph_r, cur_r, blk_r, pan_r, inc_r, scr_r, wide_r, rows_r, tall_r;
	reg nib_hi_r; // Next nibble is the high half.
	reg [3:0] nib_r; // Latched high nibble.
	reg [7:0] out_r; // Output data register for RAM reads.
	reg load_pend_r; // Refresh out_r from RAM on the next cycle.
	reg [28:0] blink_cnt_r;
	reg blink_ph_r;
	reg load_go_r; // RAM output now holds the word at the new pointer.
	reg [6:0] clr_addr_r;
	reg [7:0] byte_nxt;
	reg byte_ok;

	// Step a display address with row wrap for the active row mode.
	function [6:0] disp_step;
		input [6:0] a;
		input up;
		input rows2;
		begin
			if (rows2) begin
				if (up) begin
					if (a == `CDD_ROW1_END) disp_step = `CDD_ROW2_START;
					else if (a >= `CDD_ROW2_END) disp_step = 7'h00;
					else disp_step = a + 7'h01;
				end else begin
					if (a == 7'h00) disp_step = `CDD_ROW2_END;
					else if (a == `CDD_ROW2_START) disp_step = `CDD_ROW1_END;
					else disp_step = a - 7'h01;
				end
			end else begin
				if (up) disp_step = (a >= `CDD_ONE_ROW_END) ? 7'h00 : a + 7'h01;
				else disp_step = (a == 7'h00) ? `CDD_ONE_ROW_END : a - 7'h01;
			end
		end
	endfunction

	// Step the pointer within whichever RAM is selected.
	function [6:0] ptr_step;
		input [6:0] a;
		input up;
		input glyph;
		input rows2;
		begin
			if (glyph) ptr_step = (up ? a + 7'h01 : a - 7'h01) & `CDD_GLYPH_MASK;
			else ptr_step = disp_step(a, up, rows2);
		end
	endfunction

	// Reset release through two flip-flops.
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	// Nibble assembly: in 4-bit mode only the upper lines carry data.
	always @* begin
		byte_nxt = bus_wdata;
		byte_ok = 1'b1;
		if (!wide_r) begin
			byte_nxt = {nib_r, bus_wdata[7:4]};
			byte_ok = !nib_hi_r;
		end
	end

	wire wr_ok = bus_wr && byte_ok;
	wire idle = (state_r == ST_IDLE);
	wire inst_wr = wr_ok && !bus_addr[0] && idle;
	wire data_wr = wr_ok && bus_addr[0] && idle;
	wire data_rd = bus_rd && bus_addr[0] && byte_ok && idle;
	wire is_shift = inst_wr && (byte_nxt[7:4] == 4'h1);
	wire is_clear = inst_wr && (byte_nxt == 8'h01);
	wire is_home = inst_wr && (byte_nxt[7:1] == 7'h01);
	wire clr_we = (state_r == ST_CLEAR);

	wire disp_we = (data_wr && !glyph_r) || clr_we;
	wire [6:0] disp_addr = clr_we ? clr_addr_r : ptr_r;
	wire [7:0] disp_wd = clr_we ? `CDD_SPACE_CODE : byte_nxt;
	wire [7:0] disp_rd, glyph_rd;

	cdd_ram #(.AW(7), .DEPTH(`CDD_DISP_DEPTH)) u_disp (
		.clk(sys_clk),
		.we(disp_we),
		.addr(disp_addr),
		.wdata(disp_wd),
		.rdata(disp_rd)
	);

	cdd_ram #(.AW(6), .DEPTH(`CDD_GLYPH_DEPTH)) u_glyph (
		.clk(sys_clk),
		.we(data_wr && glyph_r),
		.addr(ptr_r[5:0]),
		.wdata(byte_nxt),
		.rdata(glyph_rd)
	);

	// Instruction execution, pointer stepping and pending timer.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			busy_cnt_r <= 21'h000000;
			ptr_r <= 7'h00;
			ofs_r <= 7'h00;
			glyph_r <= 1'b0;
			cur_r <= 1'b0;
			blk_r <= 1'b0;
			pan_r <= 1'b0;
			inc_r <= 1'b1;
			scr_r <= 1'b0;
			wide_r <= 1'b1;
			rows_r <= 1'b0;
			tall_r <= 1'b0;
			load_pend_r <= 1'b0;
			clr_addr_r <= 7'h00;
		end else begin
			load_pend_r <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				if (inst_wr) begin
					state_r <= ST_BUSY;
					busy_cnt_r <= BUSY_CYC[20:0];
					if (is_clear) begin
						state_r <= ST_CLEAR;
						clr_addr_r <= 7'h00;
						ptr_r <= 7'h00;
						ofs_r <= 7'h00;
						inc_r <= 1'b1;
						glyph_r <= 1'b0;
					end else if (is_home) begin
						busy_cnt_r <= CLEAR_CYC[20:0];
						ptr_r <= 7'h00;
						ofs_r <= 7'h00;
						glyph_r <= 1'b0;
					end else if (byte_nxt[7]) begin
						ptr_r <= byte_nxt[6:0];
						glyph_r <= 1'b0;
						load_pend_r <= 1'b1;
					end else if (byte_nxt[6]) begin
						ptr_r <= byte_nxt[6:0] & `CDD_GLYPH_MASK;
						glyph_r <= 1'b1;
						load_pend_r <= 1'b1;
					end else if (byte_nxt[5]) begin
						wide_r <= byte_nxt[4];
						rows_r <= byte_nxt[3];
						tall_r <= byte_nxt[2];
					end else if (is_shift) begin
						if (!byte_nxt[3]) begin
							ptr_r <= ptr_step(ptr_r, byte_nxt[2], glyph_r, rows_r);
							load_pend_r <= 1'b1;
						end else begin
							// One offset shared by all rows moves them together.
							ofs_r <= byte_nxt[2] ? ofs_r + 7'h01 : ofs_r - 7'h01;
						end
					end else if (byte_nxt[3]) begin
						pan_r <= byte_nxt[2];
						cur_r <= byte_nxt[1];
						blk_r <= byte_nxt[0];
					end else if (byte_nxt[2]) begin
						inc_r <= byte_nxt[1];
						scr_r <= byte_nxt[0];
					end
				end else if (data_wr || data_rd) begin
					state_r <= ST_BUSY;
					busy_cnt_r <= DATA_CYC[20:0];
					ptr_r <= ptr_step(ptr_r, inc_r, glyph_r, rows_r);
					if (data_rd) begin
						load_pend_r <= 1'b1;
					end
					if (data_wr && !glyph_r && scr_r) begin
						ofs_r <= inc_r ? ofs_r - 7'h01 : ofs_r + 7'h01;
					end
				end
			end
			ST_CLEAR: begin
				clr_addr_r <= clr_addr_r + 7'h01;
				if (clr_addr_r == 7'h7f) begin
					state_r <= ST_BUSY;
					busy_cnt_r <= CLEAR_CYC[20:0];
				end
			end
			ST_BUSY: begin
				if (busy_cnt_r <= 21'h000001) state_r <= ST_IDLE;
				else busy_cnt_r <= busy_cnt_r - 21'h000001;
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end

	// The RAM registers its read data, so the word at a freshly loaded
	// pointer appears one cycle after the request; out_r waits for it.
	// It updates only on address set, cursor shift or read, so a read after a
	// write sees the old latched byte.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			load_go_r <= 1'b0;
			out_r <= 8'h00;
		end else begin
			load_go_r <= load_pend_r;
			if (load_go_r) begin
				out_r <= glyph_r ? glyph_rd : disp_rd;
			end
		end
	end

	// Nibble phase; a function set forcing 8-bit mode also resyncs it.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			nib_hi_r <= 1'b1;
			nib_r <= 4'h0;
		end else if (wide_r) begin
			nib_hi_r <= 1'b1;
		end else if (bus_wr || bus_rd) begin
			nib_hi_r <= !nib_hi_r;
			if (bus_wr && nib_hi_r) nib_r <= bus_wdata[7:4];
		end
	end

	// Read data pipeline; nibble reads return halves on the upper lines.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= 8'h00;
		end else begin
			bus_rdata <= 8'h00;
			if (bus_rd) begin
				if (!bus_addr[0]) begin
					bus_rdata <= {!idle, ptr_r};
					if (!wide_r && !nib_hi_r) bus_rdata <= {ptr_r[3:0], 4'h0};
				end else begin
					bus_rdata <= out_r;
					if (!wide_r && !nib_hi_r) bus_rdata <= {out_r[3:0], 4'h0};
				end
			end
		end
	end

	// Blink timer; a slow enable keeps the whole block on one clock.
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			blink_cnt_r <= 29'h0000000;
			blink_ph_r <= 1'b0;
		end else if (!blk_r) begin
			blink_cnt_r <= 29'h0000000;
			blink_ph_r <= 1'b0;
		end else if (blink_cnt_r >= BLINK_CYC[28:0] - 29'h0000001) begin
			blink_cnt_r <= 29'h0000000;
			blink_ph_r <= !blink_ph_r;
		end else begin
			blink_cnt_r <= blink_cnt_r + 29'h0000001;
		end
	end

	assign internal_op_pending = !idle;
	assign cursor_on = cur_r;
	assign blink_on = blk_r;
	assign blink_phase = blink_ph_r;
	assign panel_on = pan_r;
	assign entry_inc = inc_r;
	assign scroll_on_write = scr_r;
	assign wide_bus_select = wide_r;
	assign two_rows = rows_r;
	assign tall_glyph = tall_r;
	assign screen_offset = ofs_r;
	assign address_pointer = ptr_r;
	assign glyph_sel = glyph_r;
endmodule // cdd_top

// ### rtl/cdd_defs.vh
// Constants shared by the character display command decoder.
`ifndef CDD_DEFS_VH
`define CDD_DEFS_VH
`define CDD_SPACE_CODE 8'h20
`define CDD_ROW1_END 7'h27
`define CDD_ROW2_START 7'h40
`define CDD_ROW2_END 7'h67
`define CDD_ONE_ROW_END 7'h4f
`define CDD_GLYPH_MASK 7'h3f
`define CDD_DISP_DEPTH 128
`define CDD_GLYPH_DEPTH 64
`define CDD_BUSY_NS 39000
`define CDD_CLEAR_NS 1530000
`define CDD_DATA_NS 43000
`define CDD_BLINK_NS 400000000
`define CDD_CLK_MHZ 125
`endif

// ### rtl/cdd_ram.v
// Single-port memory with registered read data for display and glyph store.
`timescale 1ns/1ps
module cdd_ram #(
	parameter AW = 7,
	parameter DEPTH = 128
) (
	clk, // Clock.
	we, // Write enable.
	addr, // Word address.
	wdata, // Write data.
	rdata // Registered read data.
);
	input wire clk;
	input wire we;
	input wire [AW-1:0] addr;
	input wire [7:0] wdata;
	output reg [7:0] rdata;
	reg [7:0] mem [0:DEPTH-1];

	// Read-first behaviour so a write cycle returns the old word.
	always @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule // cdd_ram

// ### bench/cdd_chk_assertions.sv
// Concurrent checks on the command decoder ports.
`timescale 1ns/1ps
module cdd_chk (
	input wire sys_clk, nrst, bus_wr, bus_rd, // Clock, reset, strobes.
	input wire [0:0] bus_addr, // Register select.
	input wire [7:0] bus_wdata, bus_rdata, // Host data.
	input wire internal_op_pending, cursor_on, blink_on, // Status.
	input wire blink_phase, panel_on, entry_inc, glyph_sel, // Modes.
	input wire wide_bus_select, two_rows, tall_glyph, // Format.
	input wire [6:0] screen_offset, address_pointer // Positions.
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// Only 8-bit transfers taken while idle count; busy ones are dropped.
	wire ok = ~internal_op_pending & wide_bus_select;
	wire iw = bus_wr & ~bus_addr[0] & ok;
	wire dw = bus_wr & bus_addr[0] & ok;
	chk_display_data_ram_set: assert property (iw && bus_wdata[7] |=>
		address_pointer == $past(bus_wdata[6:0]) && !glyph_sel)
		else $error("Display address set failed.");
	chk_glyph_pattern_ram_set: assert property (iw && bus_wdata[7:6] == 2'b01 |=>
		address_pointer == {1'b0, $past(bus_wdata[5:0])} && glyph_sel)
		else $error("Glyph address set failed.");
	chk_scr_shift: assert property (iw && bus_wdata[7:3] == 5'h03 |=>
		$stable(address_pointer) && screen_offset == $past(screen_offset)
		+ ($past(bus_wdata[2]) ? 7'h01 : 7'h7f)) else $error("Bad scroll.");
	chk_data_step: assert property (dw && !glyph_sel && !two_rows &&
		address_pointer > 7'h00 && address_pointer < 7'h4f |=> address_pointer
		== $past(address_pointer) + ($past(entry_inc) ? 7'h01 : 7'h7f))
		else $error("Pointer did not step after a data write.");
	chk_stat_read: assert property (bus_rd && !bus_addr[0] && ok |=>
		bus_rdata == {1'b0, $past(address_pointer)})
		else $error("Status read wrong.");
	chk_panel_ctl: assert property (iw && bus_wdata[7:3] == 5'h01 |=>
		{panel_on, cursor_on, blink_on} == $past(bus_wdata[2:0])
		&& $stable(entry_inc)) else $error("Panel control failed.");
	chk_func_set: assert property (iw && bus_wdata[7:5] == 3'b001 |=>
		{wide_bus_select, two_rows, tall_glyph} == $past(bus_wdata[4:2]))
		else $error("Function set failed.");
	chk_no_blink: assert property (!blink_on [*3] |-> $stable(blink_phase))
		else $error("Cursor flashes while disabled.");
endmodule // cdd_chk
bind cdd_top cdd_chk chk_u (.sys_clk(sys_clk), .nrst(nrst), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
	.bus_rdata(bus_rdata), .internal_op_pending(internal_op_pending),
	.cursor_on(cursor_on), .blink_on(blink_on), .blink_phase(blink_phase),
	.panel_on(panel_on), .entry_inc(entry_inc), .glyph_sel(glyph_sel),
	.wide_bus_select(wide_bus_select), .two_rows(two_rows),
	.tall_glyph(tall_glyph), .screen_offset(screen_offset),
	.address_pointer(address_pointer));

// ### bench/cdd_host.sv
// Host processor model that drives the instruction and data bus.
`timescale 1ns/1ps
module cdd_host (
	input wire sys_clk, // Clock.
	input wire pending, // Busy flag.
	input wire [7:0] bus_rdata, // Read data.
	output reg [0:0] bus_addr, // Register select.
	output reg [7:0] bus_wdata, // Write data.
	output reg bus_wr, // Write strobe.
	output reg bus_rd // Read strobe.
);
	// Quiet bus at time zero.
	initial begin
		bus_addr = 1'b0;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
	end
	// Wait for the busy flag to drop, then one spare cycle.
	task idle;
		integer n;
		begin
			n = 0;
			#1;
			while (pending !== 1'b0 && n < 3000) begin
				@(posedge sys_clk);
				#1 n = n + 1;
			end
			@(posedge sys_clk);
		end
	endtask
	// One write; released data lines show the inverse, never a stale value.
	task wr(input [0:0] a, input [7:0] v, input w);
		begin
			@(posedge sys_clk);
			bus_addr <= a;
			bus_wdata <= v;
			bus_wr <= 1'b1;
			@(posedge sys_clk);
			bus_wr <= 1'b0;
			bus_wdata <= ~v;
			if (w)
				idle;
		end
	endtask
	// One read; data is taken in the cycle after the strobe.
	task rd(input [0:0] a, output [7:0] v, input w);
		begin
			@(posedge sys_clk);
			bus_addr <= a;
			bus_rd <= 1'b1;
			@(posedge sys_clk);
			bus_rd <= 1'b0;
			#1 v = bus_rdata;
			if (w)
				idle;
		end
	endtask
endmodule // cdd_host

// ### bench/testbench.sv
// Self-checking bench for the character display command decoder.
`timescale 1ns/1ps
`define CHK(g, e) begin \
	n_tests = n_tests + 1; \
	if ((g) !== (e)) begin \
		fail_count = fail_count + 1; \
		$display("[ERR] %0t got %h want %h", $time, (g), (e)); \
	end \
end
module testbench;
	reg sys_clk, nrst;
	integer seed, fail_count, n_tests, i, k, t;
	reg [6:0] a;
	reg [7:0] d, h, mem [0:127];
	wire [0:0] bus_addr;
	wire [7:0] bus_wdata, bus_rdata;
	wire bus_wr, bus_rd, internal_op_pending, cursor_on, blink_on;
	wire blink_phase, panel_on, entry_inc, scroll_on_write, glyph_sel;
	wire wide_bus_select, two_rows, tall_glyph;
	wire [6:0] screen_offset, address_pointer;
	// Short counts keep the run brief; the status read needs a long busy.
	cdd_top #(.BUSY_CYC(8), .CLEAR_CYC(8), .DATA_CYC(4), .BLINK_CYC(16))
	dut_u (.sys_clk(sys_clk), .nrst(nrst), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .internal_op_pending(internal_op_pending),
		.cursor_on(cursor_on), .blink_on(blink_on), .blink_phase(blink_phase),
		.panel_on(panel_on), .entry_inc(entry_inc),
		.scroll_on_write(scroll_on_write), .wide_bus_select(wide_bus_select),
		.two_rows(two_rows), .tall_glyph(tall_glyph),
		.screen_offset(screen_offset), .address_pointer(address_pointer),
		.glyph_sel(glyph_sel));
	cdd_host host_u (.sys_clk(sys_clk), .pending(internal_op_pending),
		.bus_rdata(bus_rdata), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd));
	// Expected one-row pointer after a single step in the given direction.
	function [6:0] row1_step(input [6:0] p, input up);
		begin
			if (up) row1_step = (p == 7'h4f) ? 7'h00 : p + 7'h01;
			else row1_step = (p == 7'h00) ? 7'h4f : p - 7'h01;
		end
	endfunction
	// Print the counts and the verdict, then stop.
	task conclude;
		begin
			$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
			if (fail_count == 0 && n_tests > 0) begin
				$display("ALL CHECKS OK");
			end else begin
				$display("CHECKS NOT OK");
			end
			$finish;
		end
	endtask
	// Free-running 125 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// Watchdog, far beyond the fewer than a thousand cycles the tests need.
	initial begin
		#400000;
		fail_count = fail_count + 1;
		conclude;
	end
	// Main sequence.
	initial begin
		seed = 32'h15254de5;
		fail_count = 0;
		n_tests = 0;
		nrst = 1'b0;
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		`CHK({wide_bus_select, entry_inc, panel_on}, 3'b110)
		for (i = 0; i < 8; i = i + 1) begin
			host_u.wr(0, {5'b00001, i[2:0]}, 1);
			`CHK({panel_on, cursor_on, blink_on, entry_inc}, {i[2:0], 1'b1})
		end
		// With flashing on the phase turns about four times in 64 cycles.
		t = 0;
		#1;
		for (k = 0; k < 64; k = k + 1) begin
			h[0] = blink_phase;
			@(posedge sys_clk);
			#1 t = t + (blink_phase !== h[0]);
		end
		`CHK(t > 2 && t < 6, 1'b1)
		host_u.wr(0, 8'h0c, 1);
		for (i = 0; i < 4; i = i + 1) begin
			host_u.wr(0, {4'h3, i[1:0], 2'b00}, 1);
			`CHK({two_rows, tall_glyph}, i[1:0])
		end
		// Random bytes into display RAM, then read back in order.
		host_u.wr(0, 8'h30, 1);
		host_u.wr(0, 8'ha4, 1);
		for (k = 0; k < 6; k = k + 1) begin
			d = $random(seed);
			mem[36 + k] = d;
			host_u.wr(1, d, 1);
			`CHK(address_pointer, 7'h25 + k[6:0])
		end
		host_u.wr(0, 8'ha4, 1);
		for (k = 0; k < 6; k = k + 1) begin
			host_u.rd(1, d, 1);
			`CHK({d, address_pointer}, {mem[36 + k], 7'h25 + k[6:0]})
		end
		host_u.wr(0, 8'h04, 1);
		host_u.wr(1, 8'h5a, 1);
		`CHK({entry_inc, address_pointer}, 8'h29)
		host_u.wr(0, 8'h06, 1);
		// All four shift codes from the end of row one in one-row mode.
		for (i = 0; i < 4; i = i + 1) begin
			host_u.wr(0, 8'ha7, 1);
			host_u.wr(0, {4'h1, i[1:0], 2'b00}, 1);
			a = i[1] ? 7'h27 : row1_step(7'h27, i[0]);
			`CHK(address_pointer, a)
			`CHK(screen_offset, i == 2 ? 7'h7f : 7'h00)
			if (i == 1) begin
				host_u.rd(1, d, 1);
				`CHK(d, mem[40])
			end
		end
		// Two-row wrap points.
		host_u.wr(0, 8'h38, 1);
		for (i = 0; i < 2; i = i + 1) begin
			host_u.wr(0, i[0] ? 8'he7 : 8'ha7, 1);
			host_u.wr(0, 8'h14, 1);
			`CHK(address_pointer, i[0] ? 7'h00 : 7'h40)
		end
		a = $random(seed);
		d = $random(seed);
		host_u.wr(0, {2'b01, a[5:0]}, 1);
		`CHK({glyph_sel, address_pointer}, {2'b10, a[5:0]})
		host_u.wr(1, d, 1);
		host_u.wr(0, {2'b01, a[5:0]}, 1);
		host_u.rd(1, h, 1);
		`CHK(h, d)
		host_u.wr(0, {1'b1, a}, 1);
		host_u.rd(0, h, 0);
		`CHK(h, {1'b0, a})
		// Status read while busy, then a write that must be dropped.
		host_u.wr(0, 8'h80, 0);
		host_u.rd(0, h, 0);
		host_u.wr(0, 8'h85, 1);
		`CHK({h, address_pointer}, 15'h4000)
		host_u.wr(0, 8'h04, 1);
		host_u.wr(0, 8'h01, 1);
		`CHK({entry_inc, address_pointer}, 8'h80)
		host_u.wr(0, 8'h80, 1);
		host_u.rd(1, h, 1);
		`CHK(h, 8'h20)
		// Display writes with scrolling on and increment set move the whole screen left.
		host_u.wr(0, 8'h07, 1);
		host_u.wr(1, 8'h41, 1);
		`CHK({scroll_on_write, screen_offset}, 8'hff)
		// Nibble mode: high half first on the upper lines.
		host_u.wr(0, 8'h20, 1);
		`CHK(wide_bus_select, 1'b0)
		host_u.wr(0, 8'h80, 0);
		host_u.wr(0, 8'h50, 1);
		host_u.rd(0, h, 0);
		host_u.rd(0, d, 0);
		`CHK({h[7:4], d[7:4]}, 8'h05)
		host_u.wr(0, 8'h30, 0);
		host_u.wr(0, 8'h00, 1);
		`CHK(wide_bus_select, 1'b1)
		conclude;
	end
endmodule // testbench
